/* File: adr_pkg.sv */
// Shared constants and types for the serial converter readout pair.
// Assumes a single 100 MHz system clock on both ends.
package adr_pkg;

    localparam int CLK_FREQ_HZ   = 100_000_000;
    localparam int CLK_PER_US    = CLK_FREQ_HZ / 1_000_000;

    // Result width and serial frame (marker bit plus result)
    localparam int RES_BITS      = 10;
    localparam int FRAME_BITS    = RES_BITS + 1;

    // Least idle time of select before a new request, rounded up
    localparam int ACQ_TIME_NS   = 1500;
    localparam int ACQ_CYC       = (ACQ_TIME_NS * CLK_PER_US + 999) / 1000;

    // Highest shift clock rate; whole period rounded up, split in halves
    localparam int SCLK_MAX_HZ   = 2_100_000;
    localparam int SCLK_PER_CYC  = (CLK_FREQ_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
    localparam int SCLK_HALF_CYC = (SCLK_PER_CYC + 1) / 2;

    // Shortest allowed shift clock phase, high or low
    localparam int SCLK_PH_NS    = 200;
    localparam int SCLK_PH_CYC   = (SCLK_PH_NS * CLK_PER_US + 999) / 1000;

    // Internally timed conversion length
    localparam int CONV_TIME_NS  = 7500;
    localparam int CONV_CYC      = (CONV_TIME_NS * CLK_PER_US) / 1000;

    localparam int FIFO_DEPTH    = 32;

    // Three-level shutdown pin as seen by the logic
    typedef enum logic [1:0] {
        PWR_OFF     = 2'h0,
        PWR_INT_REF = 2'h1,
        PWR_EXT_REF = 2'h2
    } adr_pwr_t;

    typedef enum logic [1:0] {
        DEV_PD    = 2'h0,
        DEV_ACQ   = 2'h1,
        DEV_CONV  = 2'h2,
        DEV_SHIFT = 2'h3
    } adr_dev_state_t;

    typedef enum logic [2:0] {
        HST_ACQ  = 3'h0,
        HST_WAIT = 3'h1,
        HST_LOW  = 3'h2,
        HST_HIGH = 3'h3,
        HST_DONE = 3'h4
    } adr_host_state_t;

endpackage

/* File: adr_link_if.sv */
// Three-wire link between the converter end and the host end.
// The data line is resolved here; an undriven line reads low.
`timescale 1ns/100ps
`default_nettype none
interface adr_link_if;
    logic cs_n;
    logic sclk;
    logic dout;
    logic dout_oe;
    logic data_line;

    // Weak pull-down stands in for the floating line
    assign data_line = dout_oe ? dout : 1'b0;

    modport dev (
        input  cs_n,
        input  sclk,
        output dout,
        output dout_oe
    );

    modport host (
        output cs_n,
        output sclk,
        input  data_line
    );
endinterface
`default_nettype wire

/* File: adr_device.sv */
// Converter end: select-started conversion and serial result readout.
// Assumes cs_n and sclk come from another domain; the analog value is a
// digital word held steady around the select falling edge.
`timescale 1ns/100ps
`default_nettype none
module adr_device
    import adr_pkg::*;
#(
    parameter int RES_W       = RES_BITS,
    parameter int CONV_CYCLES = CONV_CYC
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    adr_link_if.dev               LINK,
    input  wire logic [RES_W-1:0] ANALOG_SAMPLE_INPUT,
    input  wire logic [1:0]       POWER_DOWN_INPUT,
    output logic                  REF_INT_EN,
    output logic                  OPERATIONAL,
    output logic                  CONV_BUSY
);

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);

    logic             cs_s1_q;
    logic             cs_s2_q;
    logic             cs_s3_q;
    logic             sclk_s1_q;
    logic             sclk_s2_q;
    logic             sclk_s3_q;
    logic [1:0]       pwr_s1_q;
    logic [1:0]       pwr_s2_q;
    logic             cs_fall;
    logic             sclk_fall;
    logic             powered;
    logic             conv_end;
    adr_dev_state_t   state_q;
    logic [CNT_W-1:0] conv_cnt_q;
    logic [RES_W-1:0] shift_q;
    logic             dout_q;
    logic             dout_oe_q;
    logic             ref_int_q;
    logic             oper_q;
    logic             busy_q;

    // Select and shift clock are foreign; two stages before any use
    always_ff @(posedge CLK) begin
        if (RST) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= LINK.cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else begin
            sclk_s1_q <= LINK.sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    // Pin level is quasi-static, so a plain two-stage sync is enough
    always_ff @(posedge CLK) begin
        if (RST) begin
            pwr_s1_q <= PWR_INT_REF;
            pwr_s2_q <= PWR_INT_REF;
        end else begin
            pwr_s1_q <= POWER_DOWN_INPUT;
            pwr_s2_q <= pwr_s1_q;
        end
    end

    assign cs_fall   = cs_s3_q & ~cs_s2_q;
    // edges count only with select low
    assign sclk_fall = sclk_s3_q & ~sclk_s2_q & ~cs_s2_q;
    assign powered   = (pwr_s2_q != PWR_OFF);
    assign conv_end  = (state_q == DEV_CONV) && (conv_cnt_q == CNT_W'(CONV_CYCLES - 1));

    // Power-down overrides everything; a select rise aborts any frame
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= DEV_ACQ;
        end else if (!powered) begin
            state_q <= DEV_PD;
        end else begin
            case (state_q)
                DEV_PD: begin
                    state_q <= DEV_ACQ;
                end
                DEV_ACQ: begin
                    if (cs_fall) begin
                        state_q <= DEV_CONV;
                    end
                end
                DEV_CONV: begin
                    if (cs_s2_q) begin
                        state_q <= DEV_ACQ;
                    end else if (conv_end) begin
                        state_q <= DEV_SHIFT;
                    end
                end
                DEV_SHIFT: begin
                    if (cs_s2_q) begin
                        state_q <= DEV_ACQ;
                    end
                end
                default: begin
                    state_q <= DEV_ACQ;
                end
            endcase
        end
    end

    // Conversion timer; the shift clock plays no part in it
    always_ff @(posedge CLK) begin
        if (RST) begin
            conv_cnt_q <= '0;
        end else if (state_q != DEV_CONV) begin
            conv_cnt_q <= '0;
        end else if (!conv_end) begin
            conv_cnt_q <= conv_cnt_q + CNT_W'(1);
        end
    end

    // Sample held at the start edge; a powered-down part takes none
    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_q <= '0;
        end else if ((state_q == DEV_ACQ) && cs_fall && powered) begin
            shift_q <= ANALOG_SAMPLE_INPUT;
        end else if ((state_q == DEV_SHIFT) && sclk_fall) begin
            shift_q <= {shift_q[RES_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dout_q <= 1'b0;
        end else if (state_q != DEV_SHIFT) begin
            dout_q <= conv_end;
        end else if (sclk_fall) begin
            dout_q <= shift_q[RES_W-1];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dout_oe_q <= 1'b0;
        end else begin
            dout_oe_q <= ~cs_s2_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ref_int_q <= 1'b0;
        end else begin
            ref_int_q <= (pwr_s2_q == PWR_INT_REF);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            oper_q <= 1'b0;
        end else begin
            oper_q <= powered;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q == DEV_CONV) && !conv_end;
        end
    end

    assign LINK.dout    = dout_q;
    assign LINK.dout_oe = dout_oe_q;
    assign REF_INT_EN   = ref_int_q;
    assign OPERATIONAL  = oper_q;
    assign CONV_BUSY    = busy_q;

endmodule
`default_nettype wire

/* File: adr_host.sv */
// Host end: requests samples, reads frames, queues results in a FIFO.
// Assumes the data line is foreign and a user drains RESULT_* when able.
`timescale 1ns/100ps
`default_nettype none
module adr_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module adr_host
    import adr_pkg::*;
#(
    parameter int RES_W       = RES_BITS,
    parameter int ACQ_CYCLES  = ACQ_CYC,
    parameter int HALF_CYCLES = SCLK_HALF_CYC,
    parameter int DEPTH       = FIFO_DEPTH
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    adr_link_if.host              LINK,
    input  wire logic             START,
    output logic                  READY,
    output logic                  RESULT_VALID,
    output logic      [RES_W-1:0] RESULT_DATA,
    input  wire logic             RESULT_READY
);
    localparam int AC_W = $clog2(ACQ_CYCLES + 1);
    localparam int HC_W = $clog2(HALF_CYCLES + 1);
    localparam int FR_W = $clog2(FRAME_BITS + 1);

    adr_host_state_t  state_q;
    logic [AC_W-1:0]  acq_q;
    logic [HC_W-1:0]  div_q;
    logic [FR_W-1:0]  bits_q;
    logic [RES_W:0]   rx_q;
    logic             d_s1_q;
    logic             d_s2_q;
    logic             cs_n_q;
    logic             sclk_q;
    logic             ready_q;
    logic             push_q;
    logic             fifo_in_ready;
    logic             acq_done;
    logic             tick;
    logic             take;

    assign acq_done = (acq_q == AC_W'(ACQ_CYCLES));
    assign tick     = (div_q == HC_W'(HALF_CYCLES - 1));
    assign take     = START & ready_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            d_s1_q <= 1'b0;
            d_s2_q <= 1'b0;
        end else begin
            d_s1_q <= LINK.data_line;
            d_s2_q <= d_s1_q;
        end
    end

    // idle time counted from select rise
    always_ff @(posedge CLK) begin
        if (RST || state_q != HST_ACQ) begin
            acq_q <= '0;
        end else if (!acq_done) begin
            acq_q <= acq_q + AC_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || state_q == HST_ACQ || state_q == HST_WAIT || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + HC_W'(1);
        end
    end

    // FIFO room gates new requests, so a full queue stalls sampling
    always_ff @(posedge CLK) begin
        if (RST) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (state_q == HST_ACQ) && acq_done && fifo_in_ready && !take;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= HST_ACQ;
            cs_n_q  <= 1'b1;
            sclk_q  <= 1'b0;
            bits_q  <= '0;
            rx_q    <= '0;
            push_q  <= 1'b0;
        end else begin
            push_q <= 1'b0;
            case (state_q)
                HST_ACQ: begin
                    if (take) begin
                        cs_n_q  <= 1'b0;
                        bits_q  <= '0;
                        state_q <= HST_WAIT;
                    end
                end
                HST_WAIT: begin
                    if (d_s2_q) begin
                        state_q <= HST_LOW;
                    end
                end
                HST_LOW: begin
                    if (tick) begin
                        if (bits_q == FR_W'(FRAME_BITS)) begin
                            state_q <= HST_DONE;
                        end else begin
                            sclk_q  <= 1'b1;
                            rx_q    <= {rx_q[RES_W-1:0], d_s2_q};
                            bits_q  <= bits_q + FR_W'(1);
                            state_q <= HST_HIGH;
                        end
                    end
                end
                HST_HIGH: begin
                    if (tick) begin
                        sclk_q  <= 1'b0;
                        state_q <= HST_LOW;
                    end
                end
                HST_DONE: begin
                    cs_n_q  <= 1'b1;
                    push_q  <= 1'b1;
                    state_q <= HST_ACQ;
                end
                default: begin
                    state_q <= HST_ACQ;
                end
            endcase
        end
    end

    adr_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst       (RST),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_q[RES_W-1:0]),
        .out_valid (RESULT_VALID),
        .out_ready (RESULT_READY),
        .out_data  (RESULT_DATA)
    );

    assign LINK.cs_n = cs_n_q;
    assign LINK.sclk = sclk_q;
    assign READY     = ready_q;
endmodule
`default_nettype wire

/* File: adr_link_assertions.sv */
// Checker for the three-wire link between the converter and host ends.
// Assumes it is handed the link interface signals directly.
`timescale 1ns/100ps
`default_nettype none
module adr_link_assertions #(
    parameter int CONV_CYCLES = 750,
    parameter int ACQ_CYCLES  = 150,
    parameter int PH_MIN      = 20
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic dout,
    input  wire logic dout_oe,
    input  wire logic data_line
);
    localparam int CONV_LO = CONV_CYCLES;
    localparam int CONV_HI = CONV_CYCLES + 12;
    logic [7:0] hi_q;
    logic       rise_q;
    logic       sclk_d_q;
    logic [7:0] ph_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Saturates so a long idle gap cannot wrap
    always_ff @(posedge CLK) begin
        if (RST || !cs_n) hi_q <= 8'h0;
        else if (hi_q != 8'hff) hi_q <= hi_q + 8'h1;
    end
    always_ff @(posedge CLK) begin
        if (RST || cs_n) rise_q <= 1'b0;
        else if (sclk) rise_q <= 1'b1;
    end
    always_ff @(posedge CLK) begin
        if (RST) sclk_d_q <= 1'b0;
        else sclk_d_q <= sclk;
    end
    // Length of the current shift clock level; too long a phase cannot repeat-check
    always_ff @(posedge CLK) begin
        if (RST || sclk != sclk_d_q) ph_q <= 8'h1;
        else if (ph_q != 8'hff) ph_q <= ph_q + 8'h1;
    end

    sequence s_start; $fell(cs_n); endsequence
    sequence s_idle; cs_n[*4]; endsequence
    sequence s_up; $rose(sclk) && !cs_n; endsequence

    property p_oe_on; s_start |-> ##[1:4] dout_oe; endproperty
    property p_oe_off; s_idle |-> !dout_oe; endproperty
    property p_quiet; s_start |-> !dout[*8]; endproperty
    property p_marker; s_start |-> ##[CONV_LO:CONV_HI] dout; endproperty
    property p_first; s_up and !rise_q |-> data_line; endproperty
    property p_hold; s_up |-> $stable(data_line)[*5]; endproperty
    property p_high; $fell(sclk) |-> ph_q >= PH_MIN; endproperty
    property p_low; $rose(sclk) |-> ph_q >= PH_MIN; endproperty
    property p_still; cs_n |-> !sclk; endproperty
    property p_acq; s_start |-> $past(hi_q) >= ACQ_CYCLES; endproperty

    a_oe_on: assert property (p_oe_on) else $error("data not driven after select fall");
    a_oe_off: assert property (p_oe_off) else $error("data driven while deselected");
    a_quiet: assert property (p_quiet) else $error("marker too early");
    a_marker: assert property (p_marker) else $error("marker missing");
    a_first: assert property (p_first) else $error("shift clock before marker");
    a_hold: assert property (p_hold) else $error("data moved while shift clock high");
    a_high: assert property (p_high) else $error("shift clock high phase short");
    a_low: assert property (p_low) else $error("shift clock low phase short");
    a_still: assert property (p_still) else $error("shift clock moving while deselected");
    a_acq: assert property (p_acq) else $error("select idle time short");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench joining converter and host ends over the link interface.
// Assumes package, interface, design files and checker compile first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import adr_pkg::*;
    localparam int CONV = 20;
    localparam int ACQ  = ACQ_CYC;
    logic                clk, rst, start, ready, rvalid, rready, drain;
    logic                ref_en, oper, busy, sclk_q, cs_q;
    logic [RES_BITS-1:0] analog_sample_input, rdata, e, w;
    logic [1:0]          pwr;
    logic [10:0]         sh;
    int                  fails, n_checks, nb, k;
    logic [RES_BITS-1:0] q[$], wq[$];

    adr_link_if link_i ();
    adr_device #(.CONV_CYCLES(CONV)) adr_device_i (.CLK(clk), .RST(rst), .LINK(link_i),
        .ANALOG_SAMPLE_INPUT(analog_sample_input), .POWER_DOWN_INPUT(pwr), .REF_INT_EN(ref_en),
        .OPERATIONAL(oper), .CONV_BUSY(busy));
    adr_host #(.ACQ_CYCLES(ACQ), .HALF_CYCLES(SCLK_HALF_CYC)) adr_host_i (.CLK(clk), .RST(rst), .LINK(link_i),
        .START(start), .READY(ready), .RESULT_VALID(rvalid), .RESULT_DATA(rdata), .RESULT_READY(rready));
    adr_link_assertions #(.CONV_CYCLES(CONV), .ACQ_CYCLES(ACQ), .PH_MIN(SCLK_PH_CYC)) adr_link_assertions_i (.CLK(clk),
        .RST(rst), .cs_n(link_i.cs_n), .sclk(link_i.sclk), .dout(link_i.dout),
        .dout_oe(link_i.dout_oe), .data_line(link_i.data_line));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Analog word held until the next request, past the sampling point
    task automatic frame(logic [RES_BITS-1:0] v);
        for (k = 0; ready !== 1'b1 && k < 3000; k++) tick();
        analog_sample_input = v;
        start = 1'b1;
        q.push_back(v);
        wq.push_back(v);
        tick();
        start = 1'b0;
        for (k = 0; busy !== 1'b1 && k < 10; k++) tick();
        `CHK("busy", 1'b1, busy)
    endtask

    task automatic empty_q();
        for (k = 0; q.size() > 0 && k < 20000; k++) tick();
        tick(5);
        `CHK("drained", 1'b0, rvalid)
    endtask

    always @(posedge clk) begin
        #1;
        rready = drain && ($urandom % 2 == 0);
    end

    // Wire view: host samples on the shift clock rise
    always @(negedge clk) begin
        if (cs_q === 1'b1 && link_i.cs_n === 1'b0) nb = 0;
        if (sclk_q === 1'b0 && link_i.sclk === 1'b1 && link_i.cs_n === 1'b0) begin
            sh = {sh[9:0], link_i.data_line};
            nb++;
        end
        if (cs_q === 1'b0 && link_i.cs_n === 1'b1 && wq.size() > 0) begin
            w = wq.pop_front();
            `CHK("bit count", FRAME_BITS, nb)
            `CHK("frame", {1'b1, w}, sh)
        end
        sclk_q = link_i.sclk;
        cs_q = link_i.cs_n;
    end

    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = q.pop_front();
            `CHK("result", e, rdata)
        end
    end

    // Run needs about 31000 cycles; allow nearly three times that
    initial begin
        #900_000;
        fails++;
        results();
    end

    initial begin
        void'($urandom(58));
        {rst, start, drain, rready, nb, fails, n_checks} = '0;
        rst = 1'b1;
        analog_sample_input = '0;
        pwr = 2'h2;
        tick(20);
        rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            pwr = 2'(m);
            tick(6);
            `CHK("operational", (m != 0), oper)
            `CHK("int ref", (m == 1), ref_en)
        end
        $display("test power modes done");
        drain = 1'b1;
        frame(10'h3ff);
        frame(10'h000);
        repeat (6) frame(10'($urandom));
        empty_q();
        $display("test back to back done");
        drain = 1'b0;
        repeat (FIFO_DEPTH) frame(10'($urandom));
        tick(900);
        `CHK("ready when full", 1'b0, ready)
        start = 1'b1;
        tick(50);
        start = 1'b0;
        `CHK("select held", 1'b1, link_i.cs_n)
        `CHK("data waiting", 1'b1, rvalid)
        drain = 1'b1;
        empty_q();
        $display("test fill and drain done");
        results();
    end
endmodule
`default_nettype wire
